// *** bench/rxeq_fe_model.sv ***
`timescale 1ns/1ps
module rxeq_fe_model import rxeq_pkg::*; (
	input wire logic core_clk,
	input wire rxeq_pin_s [3:0] want,
	input wire logic [3:0] frame_req,
	output rxeq_pin_s [3:0] link_pins,
	output logic [3:0] bc_frame_start
);
	// Quiet front end until the first edge
	initial begin
		link_pins = '0;
		bc_frame_start = 4'h0;
	end
	// Analog status settles one edge after the bench asks for it
	always @(posedge core_clk) begin
		link_pins <= want;
	end
	// One back-channel frame start per request cycle
	always @(posedge core_clk) begin
		bc_frame_start <= frame_req;
	end
endmodule

// *** bench/tb_top.sv ***
`timescale 1ns/1ps
`include "rxeq_map.svh"
module tb_top import rxeq_pkg::*;;
	localparam int BASE = 4;
	localparam logic [7:0] RA [8] = '{8'h4C, 8'hD0, 8'hD1, 8'hD2, 8'hD4, 8'hD5, 8'hBF, 8'hC7};
	localparam logic [7:0] RV [8] = '{8'h01, 8'h00, 8'h43, 8'h94, 8'h60, 8'hF2, 8'h00, 8'h00};
	logic core_clk = 1'b0;
	logic rstn = 1'b0;
	logic [7:0] reg_addr = 8'h00;
	logic [7:0] reg_wdata = 8'h00;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [7:0] reg_rdata;
	rxeq_pin_s [3:0] want = '0;
	logic [3:0] frame_req = 4'h0;
	rxeq_pin_s [3:0] link_pins;
	logic [3:0] bc_frame_start;
	logic [3:0] bc_corrupt;
	logic [3:0] rx_lock;
	logic [3:0][5:0] eq_setting;
	int fails = 0;
	int tests_run = 0;

	rxeq_fe_model i_fe (.core_clk(core_clk), .want(want), .frame_req(frame_req),
		.link_pins(link_pins), .bc_frame_start(bc_frame_start));
	rxeq_top #(.RELOCK_BASE_CYC(BASE)) i_dut (.core_clk(core_clk), .rstn(rstn),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .link_pins(link_pins), .bc_frame_start(bc_frame_start),
		.bc_corrupt(bc_corrupt), .rx_lock(rx_lock), .eq_setting(eq_setting));

	// Free-running core clock
	initial begin
		forever #20 core_clk = ~core_clk;
	end

	task automatic test_done();
		if (fails == 0 && tests_run > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		tests_run++;
		if (got !== exp) begin
			fails++;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic gap(input int k);
		repeat (k) @(posedge core_clk);
	endtask

	// One-cycle write strobe
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge core_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge core_clk);
		reg_wr <= 1'b0;
	endtask

	// One-cycle read strobe, data looked at after the read edge
	task automatic rd(input logic [7:0] a, input logic [7:0] m, input logic [7:0] exp);
		@(posedge core_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge core_clk);
		reg_rd <= 1'b0;
		#1;
		chk(reg_rdata & m, exp);
	endtask

	task automatic sel(input logic [1:0] p, input logic [3:0] wen);
		wr(`RXEQ_PORT_SEL_ADDR, {2'b00, p, wen});
	endtask

	// Frame start on one port, corruption looked at one cycle after it is taken
	task automatic frame(input int p, input logic exp);
		@(posedge core_clk);
		frame_req[p] <= 1'b1;
		@(posedge core_clk);
		frame_req[p] <= 1'b0;
		@(posedge core_clk);
		#1;
		chk({7'h00, bc_corrupt[p]}, {7'h00, exp});
	endtask

	task automatic wait_eq(input int p, input logic [5:0] v);
		int k;
		for (k = 0; k < 300 && eq_setting[p] !== v; k++) @(posedge core_clk) #1;
		chk({2'b00, eq_setting[p]}, {2'b00, v});
		if (k == 300) test_done();
	endtask

	// Cycles from the last setting change to the next one
	task automatic step_time(input int p, input int exp);
		int c;
		logic [5:0] s;
		s = eq_setting[p];
		for (c = 0; c < 1000 && eq_setting[p] === s; c++) @(posedge core_clk) #1;
		chk(c[7:0], exp[7:0]);
	endtask

	task automatic wait_lock(input logic v);
		int k;
		for (k = 0; k < 300 && rx_lock[0] !== v; k++) @(posedge core_clk) #1;
		chk({7'h00, rx_lock[0]}, {7'h00, v});
		if (k == 300) test_done();
	endtask

	// Main sequence
	initial begin
		gap(5);
		rstn <= 1'b1;
		wr(8'hBF, 8'hFF);
		wr(8'hD1, 8'h00);
		wr(8'hC7, 8'hFF);
		for (int i = 0; i < 8; i++) rd(RA[i], 8'hFF, RV[i]);
		// Paged writes and reads
		sel(0, 4'hF);
		wr(`RXEQ_LIMITS_ADDR, 8'h83);
		sel(0, 4'h2);
		wr(`RXEQ_LIMITS_ADDR, 8'h5A);
		sel(0, 4'h0);
		wr(`RXEQ_LIMITS_ADDR, 8'h11);
		for (int p = 0; p < 4; p++) begin
			sel(p[1:0], 4'h0);
			rd(`RXEQ_LIMITS_ADDR, 8'hFF, (p == 1) ? 8'h5A : 8'h83);
		end
		// Status flags and delay fields
		@(posedge core_clk);
		want[2].selftest <= 1'b1;
		want[1].settled <= 1'b1;
		want[1].clk_dly <= 6'h2D;
		want[1].dat_dly <= 6'h16;
		gap(6);
		sel(1, 4'h0);
		rd(`RXEQ_SF_A_ADDR, 8'h40, 8'h00);
		rd(`RXEQ_SF_A_ADDR, 8'h40, 8'h40);
		@(posedge core_clk);
		want[1].at_limit <= 1'b1;
		want[3].at_limit <= 1'b1;
		want[1].fault <= 1'b1;
		want[1].settled <= 1'b0;
		gap(6);
		want[1].at_limit <= 1'b0;
		want[3].at_limit <= 1'b0;
		want[1].fault <= 1'b0;
		want[1].settled <= 1'b1;
		gap(6);
		rd(`RXEQ_SF_A_ADDR, 8'hFF, 8'hAD);
		rd(`RXEQ_SF_A_ADDR, 8'hFF, 8'h6D);
		rd(`RXEQ_SF_B_ADDR, 8'hFF, 8'h56);
		rd(`RXEQ_SF_B_ADDR, 8'hFF, 8'h16);
		sel(3, 4'h0);
		rd(`RXEQ_SF_A_ADDR, 8'h80, 8'h80);
		rd(`RXEQ_SF_A_ADDR, 8'h80, 8'h00);
		sel(2, 4'h0);
		rd(`RXEQ_DEBUG_ADDR, 8'h20, 8'h20);
		sel(0, 4'h1);
		rd(`RXEQ_DEBUG_ADDR, 8'h20, 8'h00);
		// Back-channel error injection
		wr(`RXEQ_DEBUG_ADDR, 8'h01);
		frame(0, 1'b1);
		frame(0, 1'b0);
		rd(`RXEQ_DEBUG_ADDR, 8'h01, 8'h00);
		wr(`RXEQ_DEBUG_ADDR, 8'h02);
		frame(0, 1'b1);
		frame(0, 1'b1);
		frame(1, 1'b0);
		wr(`RXEQ_DEBUG_ADDR, 8'h00);
		frame(0, 1'b0);
		// Manual setting in bypass
		sel(2, 4'h4);
		wr(`RXEQ_MANUAL_ADDR, 8'hA5);
		wait_eq(2, 6'h2A);
		rd(`RXEQ_STATE_ADDR, 8'hFF, 8'h2A);
		// Adaptive stepping from the floor, wrapping back to the floor at the maximum
		sel(0, 4'h1);
		wr(`RXEQ_LIMITS_ADDR, 8'h75);
		wr(`RXEQ_CTL2_ADDR, 8'h0C);
		gap(3);
		wait_eq(0, 6'h05);
		wait_eq(0, 6'h06);
		step_time(0, BASE);
		step_time(0, BASE);
		chk({2'b00, eq_setting[0]}, 8'h05);
		rd(`RXEQ_CTL2_ADDR, 8'h08, 8'h00);
		wr(`RXEQ_CTL2_ADDR, 8'h4C);
		gap(3);
		wait_eq(0, 6'h06);
		step_time(0, BASE << 2);
		wr(`RXEQ_CTL2_ADDR, 8'h08);
		wait_eq(0, 6'h00);
		// Qualified lock
		wr(`RXEQ_MANUAL_ADDR, 8'h10);
		wr(`RXEQ_CTL2_ADDR, 8'h08);
		gap(3);
		want[0].lock <= 1'b1;
		gap(2);
		chk({7'h00, rx_lock[0]}, 8'h00);
		wait_lock(1'b1);
		wr(`RXEQ_MANUAL_ADDR, 8'h00);
		want[0].lock <= 1'b0;
		wait_lock(1'b0);
		want[0].lock <= 1'b1;
		gap(5);
		chk({7'h00, rx_lock[0]}, 8'h01);
		// Mid-run reset, then first lock with first-lock mode on
		rstn <= 1'b0;
		want[0].lock <= 1'b0;
		gap(5);
		rstn <= 1'b1;
		rd(`RXEQ_PORT_SEL_ADDR, 8'hFF, 8'h01);
		wr(`RXEQ_CTL2_ADDR, 8'h14);
		want[0].lock <= 1'b1;
		wait_eq(0, 6'h00);
		test_done();
	end
endmodule

// *** core/rxeq_adapt.sv ***
`timescale 1ns/1ps
`include "rxeq_map.svh"
module rxeq_adapt import rxeq_pkg::*; #(
	parameter int BASE_CYC = 4100,
	parameter int TW = 20
) (
	input wire logic core_clk,
	input wire logic rstn,
	input wire rxeq_cfg_s cfg,
	input wire logic restart,
	input wire logic lock_in,
	output logic [5:0] eq_setting,
	output logic lock_out
);
	logic [3:0] value;
	logic [TW-1:0] timer;
	logic done;
	logic seen_lock;
	logic [TW-1:0] wait_lim;
	logic [3:0] start_val;
	logic first_hit;
	logic expired;

	assign wait_lim = TW'(BASE_CYC) << cfg.relock;
	assign start_val = cfg.floor_en ? cfg.floor : 4'h0;
	assign first_hit = cfg.first_lock && lock_in && !seen_lock;
	assign expired = timer >= wait_lim - TW'(1);

	// Remember that the receiver has locked once
	always_ff @(posedge core_clk) begin
		if (!rstn)
			seen_lock <= 1'b0;
		else if (lock_in)
			seen_lock <= 1'b1;
	end

	// Adaptation engine
	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			value <= `RXEQ_FLOOR_RST;
			timer <= '0;
			done <= 1'b0;
		end else if (restart) begin
			value <= start_val;
			timer <= '0;
			done <= 1'b0;
		end else if (first_hit) begin
			value <= 4'h0;
			timer <= '0;
			done <= 1'b0;
		end else if (cfg.bypass) begin
			timer <= '0;
			done <= 1'b1;
		end else if (!lock_in) begin
			done <= 1'b0;
			timer <= expired ? '0 : timer + TW'(1);
			// wrap to start at the cap
			if (expired)
				value <= (value >= cfg.maxv) ? start_val : value + 4'h1;
		end else if (!done) begin
			timer <= expired ? '0 : timer + TW'(1);
			done <= expired;
		end
	end

	// Applied setting and qualified lock
	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			eq_setting <= 6'h00;
			lock_out <= 1'b0;
		end else begin
			eq_setting <= cfg.bypass ? {cfg.stage1, cfg.stage2} : {2'b00, value};
			lock_out <= cfg.lock_mode ? (lock_in && done) : lock_in;
		end
	end

	a_step_up: assert property (@(posedge core_clk) disable iff (!rstn)
		!restart && !first_hit && !cfg.bypass && !lock_in && expired && value < cfg.maxv
		|=> value == $past(value) + 4'h1) else $error("equalizer did not step");
endmodule

// *** core/rxeq_sync.sv ***
`timescale 1ns/1ps
module rxeq_sync import rxeq_pkg::*; #(
	parameter int WIDTH = 1
) (
	input wire logic core_clk,
	input wire logic rstn,
	input wire logic [WIDTH-1:0] d,
	output logic [WIDTH-1:0] q
);
	logic [WIDTH-1:0] meta;

	// Two-stage synchroniser; only q reads meta
	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			meta <= '0;
			q <= '0;
		end else begin
			meta <= d;
			q <= meta;
		end
	end
endmodule

// *** core/rxeq_top.sv ***
`timescale 1ns/1ps
`include "rxeq_map.svh"
module rxeq_top import rxeq_pkg::*; #(
	parameter int PORTS = 4,
	parameter int RELOCK_BASE_CYC = `RXEQ_RELOCK_BASE_NS / `RXEQ_CLK_PERIOD_NS,
	parameter int TW = 20
) (
	input wire logic core_clk,
	input wire logic rstn,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	input wire rxeq_pin_s [PORTS-1:0] link_pins,
	input wire logic [PORTS-1:0] bc_frame_start,
	output logic [PORTS-1:0] bc_corrupt,
	output logic [PORTS-1:0] rx_lock,
	output logic [PORTS-1:0][5:0] eq_setting
);
	localparam rxeq_cfg_s CFG_RST = '{
		relock: `RXEQ_RELOCK_RST,
		first_lock: `RXEQ_FIRST_LOCK_RST,
		floor_en: `RXEQ_FLOOR_EN_RST,
		stage1: `RXEQ_STAGE1_RST,
		lock_mode: 1'b0,
		stage2: `RXEQ_STAGE2_RST,
		bypass: 1'b0,
		maxv: `RXEQ_MAX_RST,
		floor: `RXEQ_FLOOR_RST,
		bc_cont: 1'b0
	};

	rxeq_pin_s [PORTS-1:0] pins_s;
	rxeq_cfg_s cfg [PORTS];
	logic [PORTS-1:0] once_pend;
	logic [PORTS-1:0] restart_req;
	logic [PORTS-1:0] limit_flag;
	logic [PORTS-1:0] settled_latch;
	logic [PORTS-1:0] fault_flag;
	logic [1:0] rd_sel;
	logic [PORTS-1:0] wr_en;
	logic [7:0] next_rdata;
	rxeq_cfg_s sel_cfg;
	rxeq_pin_s sel_pin;
	logic [5:0] sel_eq;
	logic wr_debug;
	logic wr_ctl2;
	logic wr_manual;
	logic wr_limits;
	logic rd_sf_a;
	logic rd_sf_b;

	// Synchronise every link_pins input; bc_frame_start is used unsynchronised
	rxeq_sync #(
		.WIDTH(PORTS * $bits(rxeq_pin_s))
	) u_sync (
		.core_clk(core_clk),
		.rstn(rstn),
		.d(link_pins),
		.q(pins_s)
	);

	// Decoded accesses
	assign wr_debug = reg_wr && (reg_addr == `RXEQ_DEBUG_ADDR);
	assign wr_ctl2 = reg_wr && (reg_addr == `RXEQ_CTL2_ADDR);
	assign wr_manual = reg_wr && (reg_addr == `RXEQ_MANUAL_ADDR);
	assign wr_limits = reg_wr && (reg_addr == `RXEQ_LIMITS_ADDR);
	assign rd_sf_a = reg_rd && (reg_addr == `RXEQ_SF_A_ADDR);
	assign rd_sf_b = reg_rd && (reg_addr == `RXEQ_SF_B_ADDR);

	// Port-select register
	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			rd_sel <= 2'(`RXEQ_PORT_SEL_RST >> `RXEQ_SEL_RD_LO);
			wr_en <= PORTS'(`RXEQ_PORT_SEL_RST);
		end else if (reg_wr && reg_addr == `RXEQ_PORT_SEL_ADDR) begin
			rd_sel <= reg_wdata[`RXEQ_SEL_RD_HI:`RXEQ_SEL_RD_LO];
			wr_en <= reg_wdata[PORTS-1:0];
		end
	end

	generate
		for (genvar p = 0; p < PORTS; p++) begin : g_port
			logic rd_this;

			// side effects for the read page only
			assign rd_this = (rd_sel == 2'(p));

			// paged write into each enabled copy
			always_ff @(posedge core_clk) begin
				if (!rstn) begin
					cfg[p] <= CFG_RST;
				end else if (wr_en[p]) begin
					if (wr_debug)
						cfg[p].bc_cont <= reg_wdata[`RXEQ_DBG_CONT];
					if (wr_ctl2) begin
						cfg[p].relock <= reg_wdata[`RXEQ_CTL2_RELOCK_LO +: 3];
						cfg[p].first_lock <= reg_wdata[`RXEQ_CTL2_FIRST];
						cfg[p].floor_en <= reg_wdata[`RXEQ_CTL2_FLOOR_EN];
					end
					if (wr_manual) begin
						cfg[p].stage1 <= reg_wdata[`RXEQ_MAN_STAGE1_LO +: 3];
						cfg[p].lock_mode <= reg_wdata[`RXEQ_MAN_LOCK_MODE];
						cfg[p].stage2 <= reg_wdata[`RXEQ_MAN_STAGE2_LO +: 3];
						cfg[p].bypass <= reg_wdata[`RXEQ_MAN_BYPASS];
					end
					if (wr_limits) begin
						cfg[p].maxv <= reg_wdata[`RXEQ_LIM_MAX_LO +: 4];
						cfg[p].floor <= reg_wdata[3:0];
					end
				end
			end

			// one pending error, consumed by the next frame
			always_ff @(posedge core_clk) begin
				if (!rstn)
					once_pend[p] <= 1'b0;
				else if (wr_en[p] && wr_debug && reg_wdata[`RXEQ_DBG_ONCE])
					once_pend[p] <= 1'b1;
				else if (bc_frame_start[p])
					once_pend[p] <= 1'b0;
			end

			always_ff @(posedge core_clk) begin
				if (!rstn)
					bc_corrupt[p] <= 1'b0;
				else
					bc_corrupt[p] <= bc_frame_start[p] && (cfg[p].bc_cont || once_pend[p]);
			end

			always_ff @(posedge core_clk) begin
				if (!rstn)
					restart_req[p] <= 1'b0;
				else
					restart_req[p] <= wr_en[p] && wr_ctl2 && reg_wdata[`RXEQ_CTL2_RESTART];
			end

			// limit flag, set beats read clear
			always_ff @(posedge core_clk) begin
				if (!rstn)
					limit_flag[p] <= 1'b0;
				else if (pins_s[p].at_limit)
					limit_flag[p] <= 1'b1;
				else if (rd_sf_a && rd_this)
					limit_flag[p] <= 1'b0;
			end

			always_ff @(posedge core_clk) begin
				if (!rstn)
					settled_latch[p] <= 1'b0;
				else if (!pins_s[p].settled)
					settled_latch[p] <= 1'b0;
				else if (rd_sf_a && rd_this)
					settled_latch[p] <= 1'b1;
			end

			// fault flag, set beats read clear
			always_ff @(posedge core_clk) begin
				if (!rstn)
					fault_flag[p] <= 1'b0;
				else if (pins_s[p].fault)
					fault_flag[p] <= 1'b1;
				else if (rd_sf_b && rd_this)
					fault_flag[p] <= 1'b0;
			end

			// Equalizer engine for this port
			rxeq_adapt #(
				.BASE_CYC(RELOCK_BASE_CYC),
				.TW(TW)
			) u_adapt (
				.core_clk(core_clk),
				.rstn(rstn),
				.cfg(cfg[p]),
				.restart(restart_req[p]),
				.lock_in(pins_s[p].lock),
				.eq_setting(eq_setting[p]),
				.lock_out(rx_lock[p])
			);
		end
	endgenerate

	assign sel_cfg = cfg[rd_sel];
	assign sel_pin = pins_s[rd_sel];
	assign sel_eq = eq_setting[rd_sel];

	// Read data mux
	always_comb begin
		next_rdata = 8'h00;
		case (reg_addr)
			`RXEQ_PORT_SEL_ADDR: next_rdata = {2'b00, rd_sel, wr_en};
			`RXEQ_DEBUG_ADDR: next_rdata = {2'b00, sel_pin.selftest, 3'b000,
				sel_cfg.bc_cont, once_pend[rd_sel]};
			`RXEQ_SPARE_D1_ADDR: next_rdata = `RXEQ_SPARE_D1_VAL;
			`RXEQ_CTL2_ADDR: next_rdata = {sel_cfg.relock, sel_cfg.first_lock,
				restart_req[rd_sel], sel_cfg.floor_en, 2'b00};
			`RXEQ_STATE_ADDR: next_rdata = {2'b00, sel_eq};
			`RXEQ_MANUAL_ADDR: next_rdata = {sel_cfg.stage1, sel_cfg.lock_mode,
				sel_cfg.stage2, sel_cfg.bypass};
			`RXEQ_LIMITS_ADDR: next_rdata = {sel_cfg.maxv, sel_cfg.floor};
			`RXEQ_SF_A_ADDR: next_rdata = {limit_flag[rd_sel], settled_latch[rd_sel],
				sel_pin.clk_dly};
			`RXEQ_SF_B_ADDR: next_rdata = {1'b0, fault_flag[rd_sel], sel_pin.dat_dly};
			default: next_rdata = 8'h00;
		endcase
	end

	// Read data register, loaded on each read
	always_ff @(posedge core_clk) begin
		if (!rstn)
			reg_rdata <= 8'h00;
		else if (reg_rd)
			reg_rdata <= next_rdata;
	end

	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (!rstn);

	a_read_page: assert property (
		reg_rd && reg_addr == `RXEQ_LIMITS_ADDR
		|=> reg_rdata == $past({sel_cfg.maxv, sel_cfg.floor}))
		else $error("paged read returned wrong copy");

	a_write_page: assert property (
		reg_wr && reg_addr == `RXEQ_LIMITS_ADDR && wr_en[0]
		|=> cfg[0].maxv == $past(reg_wdata[7:4]) && cfg[0].floor == $past(reg_wdata[3:0]))
		else $error("enabled port copy not written");

	a_selftest_flag: assert property (
		reg_rd && reg_addr == `RXEQ_DEBUG_ADDR
		|=> reg_rdata[5] == $past(sel_pin.selftest))
		else $error("self-test flag mismatch");

	a_cont_error: assert property (
		bc_frame_start[0] && cfg[0].bc_cont |=> bc_corrupt[0])
		else $error("continuous error not injected");

	a_single_error: assert property (
		once_pend[0] && bc_frame_start[0] && !(wr_en[0] && wr_debug)
		|=> bc_corrupt[0] && !once_pend[0])
		else $error("single error not injected once");

	a_restart_clear: assert property (
		restart_req[0] && !(wr_en[0] && wr_ctl2) |=> !restart_req[0])
		else $error("restart bit did not self-clear");

	a_bypass_value: assert property (
		cfg[0].bypass ##1 cfg[0].bypass
		|-> eq_setting[0] == {$past(cfg[0].stage1), $past(cfg[0].stage2)})
		else $error("bypass setting mismatch");

	a_lock_plain: assert property (
		!cfg[0].lock_mode |=> rx_lock[0] == $past(pins_s[0].lock))
		else $error("plain lock not followed");

	a_limit_set: assert property (
		pins_s[0].at_limit |=> limit_flag[0] [*1] ##0 limit_flag[0])
		else $error("limit flag not set");

	a_settled_low: assert property (
		!pins_s[0].settled |=> !settled_latch[0])
		else $error("settled flag not latched low");

	a_fault_clear: assert property (
		rd_sf_b && rd_sel == 2'd0 && !pins_s[0].fault |=> !fault_flag[0])
		else $error("fault flag not cleared by read");

	c_once_inject: cover property (once_pend[0] ##1 bc_corrupt[0]);
	c_bypass_on: cover property ($rose(cfg[0].bypass));
	c_restart: cover property (restart_req[1]);
	c_flag_clear: cover property (limit_flag[2] ##1 !limit_flag[2]);
endmodule

// *** shared/rxeq_map.svh ***
// Overview of operation
// - Paged reads return the port picked by port-select bits 5:4, codes 0 to 3.
// - Paged writes update every port whose port-select write-enable bit 0..3 is set.
// - Debug bit 5 shows that the remote serializer reports self-test mode.
// - Continuous-error bit set corrupts every back-channel frame sent on that port.
// - Single-error bit corrupts exactly one back-channel frame, then clears itself.
// - Three-bit relock wait, doubling 164 us to 21.0 ms, reset code 4.
// - First-lock mode one restarts adaptation at zero on initial receiver lock.
// - Restart bit 3 restarts adaptation from initial value and self-clears.
// - Floor enable, reset one, starts adaptation at the floor instead of zero.
// - Four-bit floor field, reset 2, is the start setting when floor enabled.
// - Four-bit maximum field, reset 15, caps the adaptive setting.
// - Bypass bit one disables adaptation; zero, the reset value, enables it.
// - In bypass, stage-one field drives setting bits 5:3, stage-two bits 2:0.
// - Lock-mode one makes reported lock also need finished adaptation.
// - Two read-only three-bit equalizer status fields at 5:3 and 2:0, reset zero.
// - Filter-at-limit flag bit 7 sets at the limit and clears on read.
// - Filter-settled bit 6 latches low on loss; a read reloads current status.
// - Read-only six-bit clock-delay value of the sampling filter.
// - Filter measurement-fault flag sets on any invalid measurement, clears on read.
// - Read-only six-bit data-delay value of the sampling filter.
`ifndef RXEQ_MAP_SVH
`define RXEQ_MAP_SVH

// Register offsets
`define RXEQ_PORT_SEL_ADDR 8'h4C
`define RXEQ_SPARE_BF_ADDR 8'hBF
`define RXEQ_DEBUG_ADDR 8'hD0
`define RXEQ_SPARE_D1_ADDR 8'hD1
`define RXEQ_CTL2_ADDR 8'hD2
`define RXEQ_STATE_ADDR 8'hD3
`define RXEQ_MANUAL_ADDR 8'hD4
`define RXEQ_LIMITS_ADDR 8'hD5
`define RXEQ_SF_A_ADDR 8'hD6
`define RXEQ_SF_B_ADDR 8'hD7

// Reset values
`define RXEQ_PORT_SEL_RST 8'h01
`define RXEQ_SPARE_D1_VAL 8'h43
`define RXEQ_RELOCK_RST 3'h4
`define RXEQ_FIRST_LOCK_RST 1'b1
`define RXEQ_FLOOR_EN_RST 1'b1
`define RXEQ_STAGE1_RST 3'h3
`define RXEQ_STAGE2_RST 3'h0
`define RXEQ_MAX_RST 4'hF
`define RXEQ_FLOOR_RST 4'h2

// Field positions
`define RXEQ_SEL_RD_HI 5
`define RXEQ_SEL_RD_LO 4
`define RXEQ_DBG_SELFTEST 5
`define RXEQ_DBG_CONT 1
`define RXEQ_DBG_ONCE 0
`define RXEQ_CTL2_RELOCK_LO 5
`define RXEQ_CTL2_FIRST 4
`define RXEQ_CTL2_RESTART 3
`define RXEQ_CTL2_FLOOR_EN 2
`define RXEQ_MAN_STAGE1_LO 5
`define RXEQ_MAN_LOCK_MODE 4
`define RXEQ_MAN_STAGE2_LO 1
`define RXEQ_MAN_BYPASS 0
`define RXEQ_LIM_MAX_LO 4

// Timing
`define RXEQ_CLK_PERIOD_NS 40
`define RXEQ_RELOCK_BASE_NS 164000

`endif

// *** shared/rxeq_pkg.sv ***
package rxeq_pkg;
	// Per-port settings written by software
	typedef struct packed {
		logic [2:0] relock;
		logic first_lock;
		logic floor_en;
		logic [2:0] stage1;
		logic lock_mode;
		logic [2:0] stage2;
		logic bypass;
		logic [3:0] maxv;
		logic [3:0] floor;
		logic bc_cont;
	} rxeq_cfg_s;

	// Per-port inputs from the analog front end
	typedef struct packed {
		logic lock;
		logic selftest;
		logic at_limit;
		logic settled;
		logic fault;
		logic [5:0] clk_dly;
		logic [5:0] dat_dly;
	} rxeq_pin_s;
endpackage
